// *** logic/sleep_wake_power_control.sv ***
// Oscillator control, real-time counter and sleep/wake sequencer
module sleep_wake_power_control #(
  parameter int unsigned SLOW_DIV = sleep_wake_pkg::SLOW_DIV
) (
  input  wire logic                         core_clk,
  input  wire logic                         reset_n,
  input  wire sleep_wake_pkg::bus_req_s     req,
  output logic                              rsp_valid,
  output logic [31:0]                       rsp_rdata,
  input  wire logic                         osc_strap,
  input  wire logic                         wake_pin,
  input  wire logic [3:0]                   supply_good,
  output logic                              osc_select,
  output logic                              tile_reset,
  output logic                              int_osc_en,
  output logic                              int_osc_slow,
  output logic                              xtal_en,
  output logic                              xtal_bias_en,
  output logic                              usb_suspend_up,
  output logic                              usb_suspend_down,
  output logic                              use_poweron_levels,
  output logic                              sleep_clk_default,
  output logic [2:0]                        power_state,
  output sleep_wake_pkg::supply_out_s       supply_out
);

  typedef sleep_wake_pkg::pwr_state_e state_t;

  logic [7:0]  osc_gen_q, osc_int_q, osc_xtal_q;
  logic [31:0] gen_q, wake_lo_q, wake_hi_q;
  logic [31:0] sup_q [6];
  logic [31:0] plain_q [4];
  logic [63:0] rtc_q;
  logic [31:0] stay_q;
  logic [13:0] div_q;
  logic        slow_tick;
  logic        strap_wait_q;
  logic        tile_reset_q;
  logic        rsp_valid_q;
  logic [31:0] rdata_q;
  logic [31:0] applied_q;
  state_t      state_q, state_d;

  wire sel_osc = req.periph == sleep_wake_pkg::PERIPH_OSC;
  wire sel_rtc = req.periph == sleep_wake_pkg::PERIPH_RTC;
  wire sel_pwr = req.periph == sleep_wake_pkg::PERIPH_PWR;
  wire wr_osc_gen  = req.write && sel_osc && req.addr == sleep_wake_pkg::OSC_GEN_OFF;
  wire wr_osc_int  = req.write && sel_osc && req.addr == sleep_wake_pkg::OSC_INT_OFF;
  wire wr_osc_xtal = req.write && sel_osc && req.addr == sleep_wake_pkg::OSC_XTAL_OFF;
  wire wr_gen      = req.write && sel_pwr && req.addr == sleep_wake_pkg::PWR_GEN_OFF;
  wire wr_wake_lo  = req.write && sel_pwr && req.addr == sleep_wake_pkg::WAKE_LO_OFF;
  wire wr_wake_hi  = req.write && sel_pwr && req.addr == sleep_wake_pkg::WAKE_HI_OFF;

  logic [5:0] wr_sup;
  logic [3:0] wr_plain;
  logic [5:0] hit_sup;
  logic [3:0] hit_plain;

  // Per-state supply words and plain storage words
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_sup
      assign hit_sup[gi] = sel_pwr && req.addr == sleep_wake_pkg::SUP_OFF[gi];
      assign wr_sup[gi]  = req.write && hit_sup[gi];
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          // R21 - stay field reset
          sup_q[gi] <= sleep_wake_pkg::SUP_RST[gi];
        end else if (wr_sup[gi]) begin
          sup_q[gi] <= req.wdata & sleep_wake_pkg::SUP_MASK;
        end
      end
    end
    for (gi = 0; gi < 4; gi++) begin : g_plain
      assign hit_plain[gi] = sel_pwr && req.addr == sleep_wake_pkg::PLAIN_OFF[gi];
      assign wr_plain[gi]  = req.write && hit_plain[gi];
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          plain_q[gi] <= 32'h0000_0000;
        end else if (wr_plain[gi]) begin
          plain_q[gi] <= req.wdata;
        end
      end
    end
  endgenerate

  // Oscillator registers; select strap is caught on the first edge after release
  wire [7:0] osc_gen_wr = req.wdata[7:0] & 8'h03;
  // R2 - reset tile on select change
  wire sel_change = wr_osc_gen && osc_gen_wr[sleep_wake_pkg::OSC_RST_BIT]
                    && (osc_gen_wr[sleep_wake_pkg::OSC_SEL_BIT] != osc_gen_q[sleep_wake_pkg::OSC_SEL_BIT]);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      strap_wait_q <= 1'b1;
      osc_gen_q    <= sleep_wake_pkg::OSC_GEN_RST;
    end else if (strap_wait_q) begin
      strap_wait_q <= 1'b0;
      // R1 - select taken from pin
      osc_gen_q    <= {7'h00, osc_strap};
    end else if (wr_osc_gen) begin
      osc_gen_q    <= osc_gen_wr;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      // R3 R4 R5 R6 - oscillator control resets
      osc_int_q    <= sleep_wake_pkg::OSC_INT_RST;
      osc_xtal_q   <= sleep_wake_pkg::OSC_XTAL_RST;
      tile_reset_q <= 1'b0;
    end else begin
      if (wr_osc_int) begin
        osc_int_q <= req.wdata[7:0] & 8'h03;
      end
      if (wr_osc_xtal) begin
        osc_xtal_q <= req.wdata[7:0] & 8'h03;
      end
      tile_reset_q <= sel_change && !strap_wait_q;
    end
  end

  // R9 - free-running counter
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rtc_q <= 64'h0;
    end else begin
      rtc_q <= rtc_q + 64'h1;
    end
  end

  // General control; sleep request set by software wins over hardware clear
  wire take_sleep = state_q == sleep_wake_pkg::run_state && gen_q[sleep_wake_pkg::GEN_SLEEP];
  wire [31:0] gen_wr = req.wdata & sleep_wake_pkg::PWR_GEN_MASK;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      // R16 - polarity resets high
      gen_q <= sleep_wake_pkg::PWR_GEN_RST;
    end else if (wr_gen) begin
      gen_q <= gen_wr;
    end else if (take_sleep) begin
      // R17 - self clearing start
      gen_q[sleep_wake_pkg::GEN_SLEEP] <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wake_lo_q <= 32'h0;
      wake_hi_q <= 32'h0;
    end else begin
      if (wr_wake_lo) begin
        wake_lo_q <= req.wdata;
      end
      if (wr_wake_hi) begin
        wake_hi_q <= req.wdata;
      end
    end
  end

  // Slow sleep clock as an enable; the count exceeds 4096 so it is a parameter
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_q <= 14'h0;
    end else if (slow_tick) begin
      div_q <= 14'h0;
    end else begin
      div_q <= div_q + 14'h1;
    end
  end
  assign slow_tick = div_q == 14'(SLOW_DIV - 1);

  // Wake conditions
  // R13 R24 - compare at or past
  wire tmr_hit32 = rtc_q[31:0] >= wake_lo_q;
  wire tmr_hit64 = rtc_q >= {wake_hi_q, wake_lo_q};
  // R20 - high word only in 64-bit mode
  wire tmr_hit   = gen_q[sleep_wake_pkg::GEN_TMR_64] ? tmr_hit64 : tmr_hit32;
  // R14 R19 - timer wake enable
  wire tmr_wake  = gen_q[sleep_wake_pkg::GEN_TMR_EN] && tmr_hit;
  // R15 R16 - pin wake at level
  wire pin_wake  = gen_q[sleep_wake_pkg::GEN_PIN_EN] && (wake_pin == gen_q[sleep_wake_pkg::GEN_PIN_POL]);
  wire wake_any  = tmr_wake || pin_wake;

  // Minimum stay, counted on the slow enable while dormant on the internal clock
  wire [4:0]  stay_log2 = applied_q[sleep_wake_pkg::SUP_LOG2_LO +: 5];
  wire [31:0] stay_max  = (32'h1 << stay_log2) - 32'h1;
  // R18 - sleep clock in dormant only
  wire in_dormant = state_q == sleep_wake_pkg::dormant;
  wire slow_mode  = in_dormant && !gen_q[sleep_wake_pkg::GEN_SLP_CLK];
  wire stay_tick  = slow_mode ? slow_tick : 1'b1;
  // R21 - minimum stay reached
  wire stay_done  = stay_q >= stay_max;
  wire [3:0] sup_en = {applied_q[5], applied_q[4], applied_q[1], applied_q[0]};
  wire supplies_ok  = (sup_en & ~supply_good) == 4'h0;

  // R25 - sequence order
  always_comb begin
    state_d = state_q;
    case (state_q)
      sleep_wake_pkg::run_state: begin
        if (take_sleep) begin
          state_d = sleep_wake_pkg::entry_phase_one;
        end
      end
      sleep_wake_pkg::entry_phase_one: begin
        if (stay_done) begin
          state_d = sleep_wake_pkg::entry_phase_two;
        end
      end
      sleep_wake_pkg::entry_phase_two: begin
        if (stay_done) begin
          state_d = sleep_wake_pkg::dormant;
        end
      end
      sleep_wake_pkg::dormant: begin
        // R22 - wait for wake
        if (stay_done && wake_any) begin
          state_d = sleep_wake_pkg::resume_phase_one;
        end
      end
      sleep_wake_pkg::resume_phase_one: begin
        // R23 - supplies good gate
        if (stay_done && supplies_ok) begin
          state_d = sleep_wake_pkg::resume_phase_two;
        end
      end
      sleep_wake_pkg::resume_phase_two: begin
        if (stay_done && supplies_ok) begin
          state_d = sleep_wake_pkg::run_state;
        end
      end
      default: begin
        state_d = sleep_wake_pkg::run_state;
      end
    endcase
  end

  wire advance = state_d != state_q;
  // R12 - re-apply run setting
  wire reapply = wr_gen && req.wdata[sleep_wake_pkg::GEN_REAPPLY] && state_q == sleep_wake_pkg::run_state;
  wire [31:0] run_cfg_new = wr_sup[0] ? (req.wdata & sleep_wake_pkg::SUP_MASK) : sup_q[0];

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q   <= sleep_wake_pkg::run_state;
      stay_q    <= 32'h0;
      applied_q <= sleep_wake_pkg::SUP_RST[0];
    end else begin
      state_q <= state_d;
      if (advance) begin
        stay_q    <= 32'h0;
        applied_q <= sup_q[state_d];
      end else begin
        if (stay_tick && !stay_done) begin
          stay_q <= stay_q + 32'h1;
        end
        if (reapply) begin
          applied_q <= run_cfg_new;
        end
      end
    end
  end

  // Register read path; unmapped addresses read zero, access width is not checked
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    if (sel_osc) begin
      // R7 - byte wide registers
      case (req.addr)
        sleep_wake_pkg::OSC_GEN_OFF:  rd_mux = {24'h0, osc_gen_q};
        sleep_wake_pkg::OSC_INT_OFF:  rd_mux = {24'h0, osc_int_q};
        sleep_wake_pkg::OSC_XTAL_OFF: rd_mux = {24'h0, osc_xtal_q};
        default:                      rd_mux = 32'h0;
      endcase
    end else if (sel_rtc) begin
      // R8 R9 - word reads of counter
      case (req.addr)
        sleep_wake_pkg::RTC_LO_OFF: rd_mux = rtc_q[31:0];
        sleep_wake_pkg::RTC_HI_OFF: rd_mux = rtc_q[63:32];
        default:                    rd_mux = 32'h0;
      endcase
    end else if (sel_pwr) begin
      case (req.addr)
        sleep_wake_pkg::PWR_GEN_OFF:  rd_mux = gen_q;
        sleep_wake_pkg::WAKE_LO_OFF:  rd_mux = wake_lo_q;
        sleep_wake_pkg::WAKE_HI_OFF:  rd_mux = wake_hi_q;
        sleep_wake_pkg::SEQ_STAT_OFF: rd_mux = {29'h0, state_q};
        default:                      rd_mux = 32'h0;
      endcase
      for (int i = 0; i < 6; i++) begin
        if (hit_sup[i]) begin
          rd_mux = sup_q[i];
        end
      end
      for (int i = 0; i < 4; i++) begin
        if (hit_plain[i]) begin
          rd_mux = plain_q[i];
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rsp_valid_q <= 1'b0;
      rdata_q     <= 32'h0;
    end else begin
      rsp_valid_q <= req.read || req.write;
      if (req.read) begin
        rdata_q <= rd_mux;
      end
    end
  end

  assign rsp_valid          = rsp_valid_q;
  assign rsp_rdata          = rdata_q;
  assign osc_select         = osc_gen_q[sleep_wake_pkg::OSC_SEL_BIT];
  assign tile_reset         = tile_reset_q;
  assign int_osc_en         = osc_int_q[sleep_wake_pkg::INT_EN_BIT];
  assign int_osc_slow       = osc_int_q[sleep_wake_pkg::INT_SLOW_BIT];
  assign xtal_en            = osc_xtal_q[sleep_wake_pkg::XTAL_EN_BIT];
  assign xtal_bias_en       = osc_xtal_q[sleep_wake_pkg::XTAL_BIAS_BIT];
  // R10 - USB suspend enables
  assign usb_suspend_up     = gen_q[sleep_wake_pkg::GEN_USB_UP];
  assign usb_suspend_down   = gen_q[sleep_wake_pkg::GEN_USB_DN];
  // R11 - level source while waking
  assign use_poweron_levels = gen_q[sleep_wake_pkg::GEN_POR_LVL];
  assign sleep_clk_default  = in_dormant && gen_q[sleep_wake_pkg::GEN_SLP_CLK];
  assign power_state        = state_q;
  assign supply_out.supply_en    = sup_en;
  assign supply_out.modulation   = applied_q[9:8];
  assign supply_out.tile_clk_off = applied_q[sleep_wake_pkg::SUP_CLK_OFF];

endmodule

// *** logic/sleep_wake_pkg.sv ***
// Constants, types and register map of the sleep and wake power control block
// Functional notes
// R1 - Oscillator general bit 0 picks crystal (0) or on-chip (1); reset from pin.
// R2 - With oscillator general bit 1 set, a change of select resets the tile.
// R3 - On-chip oscillator bit 1 picks fast (0) or slow (1) clock; resets 0.
// R4 - On-chip oscillator bit 0 resets 1; writing 0 disables that oscillator.
// R5 - Crystal bit 1 resets 1 and enables the bias circuit.
// R6 - Crystal bit 0 resets 1; writing 0 disables the crystal oscillator.
// R7 - Software uses 8-bit accesses on the three oscillator registers.
// R8 - Software uses 32-bit accesses on counter and power registers.
// R9 - 64-bit free-running counter, reset zero, read-only low and high words.
// R10 - General control bits 9 and 8 drive USB suspend up and down enables.
// R11 - Bit 7 picks stored level-control values (0) or power-on levels (1) on wake.
// R12 - Write-only bit 6 re-applies the run-state supply setting, then clears.
// R13 - Bit 5 selects a 64-bit wake comparison, otherwise 32 bits.
// R14 - Bit 4 enables wake-up on the counter reaching the wake time.
// R15 - Bit 2 enables wake-up on the wake pin at the selected level.
// R16 - Bit 3 wake polarity: resets 1 for high, 0 for low.
// R17 - Writing bit 1 starts the sleep sequence; hardware clears it.
// R18 - Bit 0 sleep clock: 0 slow internal, 1 default; effective when dormant.
// R19 - Low wake-time word, reset 0, used only with timer wake while asleep.
// R20 - High wake-time word, reset 0, ignored without 64-bit comparison.
// R21 - Per-state field 20:16 gives log2 of minimum stay; resets 16.
// R22 - Dormant leaves after minimum time only on an enabled wake condition.
// R23 - Resume phases advance after minimum time only with enabled supplies good.
// R24 - Timer wake fires when counter equals or passes wake time.
// R25 - Order run, entry one, entry two, dormant, resume one, resume two, run.
package sleep_wake_pkg;

  localparam int unsigned CLK_HZ   = 250_000_000;
  localparam int unsigned SLOW_HZ  = 31_250;
  localparam int unsigned SLOW_DIV = CLK_HZ / SLOW_HZ;

  localparam logic [7:0] PERIPH_OSC = 8'h04;
  localparam logic [7:0] PERIPH_RTC = 8'h05;
  localparam logic [7:0] PERIPH_PWR = 8'h06;

  localparam logic [7:0] OSC_GEN_OFF  = 8'h00;
  localparam logic [7:0] OSC_INT_OFF  = 8'h01;
  localparam logic [7:0] OSC_XTAL_OFF = 8'h02;
  localparam logic [7:0] RTC_LO_OFF   = 8'h00;
  localparam logic [7:0] RTC_HI_OFF   = 8'h04;
  localparam logic [7:0] PWR_GEN_OFF  = 8'h00;
  localparam logic [7:0] WAKE_LO_OFF  = 8'h04;
  localparam logic [7:0] WAKE_HI_OFF  = 8'h08;
  localparam logic [7:0] SEQ_STAT_OFF = 8'h24;

  // Per-state supply registers, indexed by state code
  localparam logic [7:0] SUP_OFF [6] = '{8'h18, 8'h1c, 8'h20, 8'h0c, 8'h10, 8'h14};
  // Plain storage words: converter, supply status, core level, pll level
  localparam logic [7:0] PLAIN_OFF [4] = '{8'h2c, 8'h30, 8'h34, 8'h40};

  localparam int OSC_SEL_BIT   = 0;
  localparam int OSC_RST_BIT   = 1;
  localparam int INT_EN_BIT    = 0;
  localparam int INT_SLOW_BIT  = 1;
  localparam int XTAL_EN_BIT   = 0;
  localparam int XTAL_BIAS_BIT = 1;

  localparam int GEN_SLP_CLK  = 0;
  localparam int GEN_SLEEP    = 1;
  localparam int GEN_PIN_EN   = 2;
  localparam int GEN_PIN_POL  = 3;
  localparam int GEN_TMR_EN   = 4;
  localparam int GEN_TMR_64   = 5;
  localparam int GEN_REAPPLY  = 6;
  localparam int GEN_POR_LVL  = 7;
  localparam int GEN_USB_DN   = 8;
  localparam int GEN_USB_UP   = 9;

  localparam logic [7:0]  OSC_GEN_RST  = 8'h00;
  localparam logic [7:0]  OSC_INT_RST  = 8'h01;
  localparam logic [7:0]  OSC_XTAL_RST = 8'h03;
  localparam logic [31:0] PWR_GEN_RST  = 32'h0000_0008;
  localparam logic [31:0] PWR_GEN_MASK = 32'h0000_03bf;

  localparam int SUP_LOG2_LO = 16;
  localparam int SUP_CLK_OFF = 14;
  localparam logic [31:0] SUP_MASK = 32'h001f_4331;
  localparam logic [31:0] SUP_RST [6] = '{32'h0010_0000, 32'h0010_0000, 32'h0010_0000,
                                          32'h0010_0000, 32'h0010_0020, 32'h0010_0000};

  typedef enum logic [2:0] {
    run_state        = 3'b000,
    entry_phase_one  = 3'b001,
    entry_phase_two  = 3'b010,
    dormant          = 3'b011,
    resume_phase_one = 3'b100,
    resume_phase_two = 3'b101
  } pwr_state_e;

  typedef struct packed {
    logic [7:0]  periph;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        write;
    logic        read;
  } bus_req_s;

  typedef struct packed {
    logic [3:0] supply_en;
    logic [1:0] modulation;
    logic       tile_clk_off;
  } supply_out_s;

endpackage

// *** dv/sleep_wake_properties.sv ***
// Port-level concurrent checks for the sleep and wake power control block
module sleep_wake_properties #(
  parameter int unsigned SLOW_DIV = 8000
) (
  input wire logic                        core_clk,
  input wire logic                        reset_n,
  input wire sleep_wake_pkg::bus_req_s    req,
  input wire logic                        rsp_valid,
  input wire logic [31:0]                 rsp_rdata,
  input wire logic [3:0]                  supply_good,
  input wire logic                        osc_select,
  input wire logic                        tile_reset,
  input wire logic                        int_osc_en,
  input wire logic                        int_osc_slow,
  input wire logic                        xtal_en,
  input wire logic                        xtal_bias_en,
  input wire logic                        usb_suspend_up,
  input wire logic                        usb_suspend_down,
  input wire logic                        use_poweron_levels,
  input wire logic                        sleep_clk_default,
  input wire logic [2:0]                  power_state,
  input wire sleep_wake_pkg::supply_out_s supply_out
);
  wire logic osc_wr = req.write && req.periph == 8'h04;
  wire logic sel_wr = osc_wr && req.addr == 8'h00;
  wire logic gen_wr = req.write && req.periph == 8'h06 && req.addr == 8'h00;
  wire logic lo_rd  = req.read && req.periph == 8'h05 && req.addr == 8'h00;
  // A supply enabled in the applied state but not reporting good
  wire logic sup_bad = |(supply_out.supply_en & ~supply_good);

  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence s_lo_pair;
    lo_rd ##1 lo_rd;
  endsequence

  a_rsp_after_req: assert property ((req.read || req.write) |=> rsp_valid)
    else $error("no answer one cycle after a request");
  a_rsp_no_spurious: assert property (!(req.read || req.write) |=> !rsp_valid)
    else $error("answer without a request");
  a_tile_rst_cause: assert property (sel_wr && req.wdata[1] && req.wdata[0] != osc_select |=> tile_reset)
    else $error("select change with reset enabled gave no tile reset");
  a_tile_rst_only: assert property (tile_reset |-> $past(sel_wr) && $past(req.wdata[1]))
    else $error("tile reset without cause");
  a_int_osc_write: assert property (osc_wr && req.addr == 8'h01 |=>
    int_osc_en == $past(req.wdata[0]) && int_osc_slow == $past(req.wdata[1]))
    else $error("on-chip oscillator outputs do not follow write");
  a_xtal_write: assert property (osc_wr && req.addr == 8'h02 |=>
    xtal_en == $past(req.wdata[0]) && xtal_bias_en == $past(req.wdata[1]))
    else $error("crystal outputs do not follow write");
  a_gen_bits_write: assert property (gen_wr |=> usb_suspend_up == $past(req.wdata[9]) &&
    usb_suspend_down == $past(req.wdata[8]) && use_poweron_levels == $past(req.wdata[7]))
    else $error("general control outputs do not follow write");
  a_rtc_step_one: assert property (s_lo_pair |=> rsp_rdata == $past(rsp_rdata) + 32'h1)
    else $error("counter did not advance by one per cycle");
  a_state_order: assert property ($changed(power_state) |->
    power_state == $past(power_state) + 3'h1 || (power_state == 3'h0 && $past(power_state) == 3'h5))
    else $error("power state left its order");
  a_sleep_clk_dorm: assert property (sleep_clk_default |-> power_state == 3'h3)
    else $error("sleep clock select active outside dormant");
  a_resume_supply: assert property ($past(power_state) >= 3'h4 && $changed(power_state) |-> !$past(sup_bad))
    else $error("resume phase advanced with a supply not good");
  a_sleep_start: assert property (gen_wr && req.wdata[1] && power_state == 3'h0 |-> ##[1:3] power_state == 3'h1)
    else $error("sleep request did not start the sequence");
endmodule

bind sleep_wake_power_control sleep_wake_properties #(.SLOW_DIV(SLOW_DIV)) u_props (
  .core_clk(core_clk), .reset_n(reset_n), .req(req), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
  .supply_good(supply_good), .osc_select(osc_select), .tile_reset(tile_reset), .int_osc_en(int_osc_en),
  .int_osc_slow(int_osc_slow), .xtal_en(xtal_en), .xtal_bias_en(xtal_bias_en),
  .usb_suspend_up(usb_suspend_up), .usb_suspend_down(usb_suspend_down),
  .use_poweron_levels(use_poweron_levels), .sleep_clk_default(sleep_clk_default),
  .power_state(power_state), .supply_out(supply_out));

// *** dv/sleep_wake_power_control_bench.sv ***
// Directed register and sequencing tests for the sleep and wake power control block
module sleep_wake_power_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                        core_clk    = 1'b0;
  logic                        reset_n     = 1'b0;
  sleep_wake_pkg::bus_req_s    req         = '0;
  logic                        osc_strap   = 1'b1;
  logic                        wake_pin    = 1'b0;
  logic [3:0]                  supply_good = 4'hf;
  logic                        rsp_valid, osc_select, tile_reset, int_osc_en, int_osc_slow;
  logic                        xtal_en, xtal_bias_en, usb_up, usb_dn, por_lvl, slp_clk;
  logic [31:0]                 rsp_rdata, d, t;
  logic [2:0]                  power_state;
  sleep_wake_pkg::supply_out_s supply_out;
  int                          err_count   = 0;
  int                          check_count = 0;
  int                          cycles      = 0;
  // Reset view: periph, offset, value; 0x28 is unmapped
  logic [7:0]  rp [11] = '{8'h04, 8'h04, 8'h04, 8'h06, 8'h06, 8'h06, 8'h06, 8'h06, 8'h06, 8'h06, 8'h05};
  logic [7:0]  ra [11] = '{8'h00, 8'h01, 8'h02, 8'h00, 8'h04, 8'h08, 8'h10, 8'h18, 8'h24, 8'h28, 8'h04};
  logic [31:0] re [11] = '{32'h1, 32'h1, 32'h3, 32'h8, 32'h0, 32'h0, 32'h0010_0020, 32'h0010_0000,
                           32'h0, 32'h0, 32'h0};

  sleep_wake_power_control #(.SLOW_DIV(4)) dut (
    .core_clk(core_clk), .reset_n(reset_n), .req(req), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .osc_strap(osc_strap), .wake_pin(wake_pin), .supply_good(supply_good), .osc_select(osc_select),
    .tile_reset(tile_reset), .int_osc_en(int_osc_en), .int_osc_slow(int_osc_slow), .xtal_en(xtal_en),
    .xtal_bias_en(xtal_bias_en), .usb_suspend_up(usb_up), .usb_suspend_down(usb_dn),
    .use_poweron_levels(por_lvl), .sleep_clk_default(slp_clk), .power_state(power_state),
    .supply_out(supply_out));

  always #2 core_clk = ~core_clk;

  // Hang guard well above the several hundred cycles the tests need
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 30000) begin
      err_count++;
      finish_test();
    end
  end

  task finish_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
      err_count++;
    end
  endtask

  task xfer(input logic [7:0] p, input logic [7:0] a, input logic [31:0] w, input logic wr);
    @(posedge core_clk);
    #1;
    req.periph = p;
    req.addr   = a;
    req.wdata  = w;
    req.write  = wr;
    req.read   = !wr;
    @(posedge core_clk);
    #1;
    req.write = 1'b0;
    req.read  = 1'b0;
    chk({31'h0, rsp_valid}, 32'h1);
    d = rsp_rdata;
  endtask

  task wr(input logic [7:0] p, input logic [7:0] a, input logic [31:0] w);
    xfer(p, a, w, 1'b1);
  endtask

  task rd(input logic [7:0] p, input logic [7:0] a);
    xfer(p, a, 32'h0, 1'b0);
  endtask

  task wait_state(input logic [2:0] s);
    int n;
    n = 0;
    while (power_state !== s && n < 3000) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk({29'h0, power_state}, {29'h0, s});
  endtask

  task hold(input logic [2:0] s, input int n);
    repeat (n) @(posedge core_clk);
    #1;
    chk({29'h0, power_state}, {29'h0, s});
  endtask

  initial begin
    repeat (8) @(posedge core_clk);
    #1;
    reset_n = 1'b1;
    chk({28'h0, int_osc_en, int_osc_slow, xtal_en, xtal_bias_en}, 32'hb);
    for (int i = 0; i < 11; i++) begin
      rd(rp[i], ra[i]);
      chk(d, re[i]);
    end
    $display("test reset_values done");

    wr(8'h04, 8'h01, 32'h2);
    chk({30'h0, int_osc_en, int_osc_slow}, 32'h1);
    wr(8'h04, 8'h02, 32'h0);
    chk({30'h0, xtal_en, xtal_bias_en}, 32'h0);
    wr(8'h04, 8'h02, 32'h3);
    wr(8'h04, 8'h01, 32'h1);
    wr(8'h04, 8'h00, 32'h2);
    chk({30'h0, osc_select, tile_reset}, 32'h1);
    wr(8'h04, 8'h00, 32'h2);
    chk({31'h0, tile_reset}, 32'h0);
    wr(8'h04, 8'h00, 32'h1);
    chk({30'h0, osc_select, tile_reset}, 32'h2);
    $display("test oscillator done");

    @(posedge core_clk);
    #1;
    req.periph = 8'h05;
    req.addr   = 8'h00;
    req.read   = 1'b1;
    @(posedge core_clk);
    #1;
    t = rsp_rdata;
    @(posedge core_clk);
    #1;
    req.read = 1'b0;
    chk(rsp_rdata - t, 32'h1);
    wr(8'h05, 8'h00, 32'h0);
    rd(8'h05, 8'h00);
    chk({31'h0, d > t}, 32'h1);
    $display("test counter done");

    wr(8'h06, 8'h00, 32'h3c8);
    chk({29'h0, usb_up, usb_dn, por_lvl}, 32'h7);
    rd(8'h06, 8'h00);
    chk(d, 32'h388);
    wr(8'h06, 8'h00, 32'h8);
    wr(8'h06, 8'h18, 32'h4313);
    rd(8'h06, 8'h18);
    chk(d, 32'h4311);
    wr(8'h06, 8'h00, 32'h48);
    chk({25'h0, supply_out}, 32'h2f);
    $display("test general_control done");

    // Shortest stays so no phase waits out a minimum time; dormant and resume one are held by wake and supplies
    for (int i = 0; i < 6; i++) begin
      wr(8'h06, sleep_wake_pkg::SUP_OFF[i], (i == 4) ? 32'h20 : 32'h0);
    end
    supply_good = 4'h7;
    wr(8'h06, 8'h00, 32'h0d);
    wr(8'h06, 8'h00, 32'h0f);
    wait_state(3'h3);
    chk({31'h0, slp_clk}, 32'h1);
    hold(3'h3, 40);
    wake_pin = 1'b1;
    wait_state(3'h4);
    hold(3'h4, 20);
    supply_good = 4'hf;
    wait_state(3'h0);
    rd(8'h06, 8'h00);
    chk(d, 32'h0d);
    // Dormant stay of 7 slow ticks outlasts the first hold
    wr(8'h06, 8'h0c, 32'h0003_0000);
    wr(8'h06, 8'h00, 32'h06);
    wait_state(3'h3);
    chk({31'h0, slp_clk}, 32'h0);
    wake_pin = 1'b0;
    hold(3'h3, 20);
    wake_pin = 1'b1;
    hold(3'h3, 40);
    wake_pin = 1'b0;
    wait_state(3'h0);
    $display("test pin_wake done");

    wr(8'h06, 8'h08, 32'h1);
    rd(8'h05, 8'h00);
    t = d + 32'h12c;
    wr(8'h06, 8'h04, t);
    wr(8'h06, 8'h00, 32'h12);
    wait_state(3'h4);
    rd(8'h05, 8'h00);
    chk({31'h0, d >= t}, 32'h1);
    chk({31'h0, d < t + 32'h40}, 32'h1);
    wait_state(3'h0);
    wr(8'h06, 8'h04, 32'h0);
    wr(8'h06, 8'h00, 32'h32);
    wait_state(3'h3);
    hold(3'h3, 100);
    wr(8'h06, 8'h08, 32'h0);
    wait_state(3'h0);
    $display("test timer_wake done");

    osc_strap = 1'b0;
    reset_n   = 1'b0;
    @(posedge core_clk);
    #1;
    reset_n = 1'b1;
    rd(8'h04, 8'h00);
    chk(d, 32'h0);
    chk({31'h0, osc_select}, 32'h0);
    $display("test strap_low done");
    finish_test();
  end
endmodule
